// [ptmr_top.sv]
// Pulse timer module top: two channels around the counter core
`timescale 1ns/1ps
module ptmr_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  clock_source_field,
  input  wire logic [2:0]  prescale_select,
  input  wire logic        center_aligned_pwm,
  input  wire logic [15:0] counter_modulo_value,
  input  wire logic        cnt_write,
  input  wire logic        ovf_clear,
  input  wire logic        fixed_system_clock,
  input  wire logic        external_clock_input,
  input  wire logic        comparator_capture_route,
  input  wire logic        analog_comparator,
  input  wire logic [1:0]  ch_mode [2],
  input  wire logic [1:0]  channel_edge_level_select [2],
  input  wire logic [15:0] ch_value_wr [2],
  input  wire logic [1:0]  ch_value_we,
  input  wire logic [1:0]  ch_flag_clear,
  input  wire logic [1:0]  timer_channel_pin_in,
  input  wire logic [1:0]  port_data,
  input  wire logic [1:0]  port_dir,
  input  wire logic [1:0]  pullup_req,
  output      logic [1:0]  timer_channel_pin_out,
  output      logic [1:0]  timer_channel_pin_oe,
  output      logic [1:0]  pin_pullup_en,
  output      logic [15:0] timer_count_value,
  output      logic [15:0] ch_value_q [2],
  output      logic [1:0]  ch_flag,
  output      logic [1:0]  ch_irq,
  output      logic        overflow_flag,
  output      logic        ovf_irq
);
  typedef struct packed {
    logic [15:0] val;
    logic [15:0] buf_val;
    logic        buf_pend;
    logic        in_d;
    logic        out;
    logic        flag;
    logic        oe;
    logic        po;
    logic        pu;
  } ptmr_ch_s;

  ptmr_tick_if tk ();
  logic        ovf_w;
  logic [15:0] cnt_q;
  logic        ovf_q2;
  logic        oirq_q;

  ptmr_core u_core (
    .clk                  (clk),
    .reset                (reset),
    .clock_source_field   (clock_source_field),
    .prescale_select      (prescale_select),
    .center_aligned_pwm   (center_aligned_pwm),
    .counter_modulo_value (counter_modulo_value),
    .cnt_write            (cnt_write),
    .ovf_clear            (ovf_clear),
    .fixed_system_clock   (fixed_system_clock),
    .external_clock_input (external_clock_input),
    .ovf_q                (ovf_w),
    .tk                   (tk.core)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= ptmr_pkg::PTMR_CNT_RST;
      ovf_q2 <= 1'b0;
      oirq_q <= 1'b0;
    end else begin
      cnt_q  <= tk.cnt; // RULE7
      ovf_q2 <= ovf_w;
      oirq_q <= ovf_w; // RULE21
    end
  end
  assign timer_count_value = cnt_q;
  assign overflow_flag     = ovf_q2;
  assign ovf_irq           = oirq_q;

  // RULE16 RULE25
  for (genvar i = 0; i < ptmr_pkg::PTMR_NCH; i++) begin : g_ch
    ptmr_ch_s c_q;
    ptmr_ch_s c_d;
    logic     pin_in;
    logic     rise;
    logic     fall;
    logic     hit;
    logic     active;
    logic     pwm_lvl;
    logic     set_ev;

    always_comb begin
      c_d    = c_q;
      // Comparator replaces pin 0 as the capture source
      pin_in = (i == 0 && comparator_capture_route) ? analog_comparator
                                                    : timer_channel_pin_in[i]; // RULE1
      c_d.in_d = pin_in;
      rise   = pin_in & ~c_q.in_d;
      fall   = ~pin_in & c_q.in_d;
      hit    = (tk.cnt == c_q.val);
      active = (channel_edge_level_select[i] != 2'h0); // RULE13
      pwm_lvl = 1'b0;
      set_ev  = 1'b0;
      if (ch_value_we[i]) begin
        c_d.buf_val  = ch_value_wr[i];
        c_d.buf_pend = 1'b1;
      end
      if (center_aligned_pwm || ch_mode[i][1]) begin // RULE17
        // Buffered value loads at period boundary to avoid glitches
        if (c_q.buf_pend && tk.tick && (tk.at_mod || tk.cnt == 16'h0000)) begin
          c_d.val      = c_q.buf_val;
          c_d.buf_pend = ch_value_we[i];
        end
        pwm_lvl = center_aligned_pwm ? (tk.cnt < c_q.val) : (tk.cnt < c_q.val);
        // ELS 1:0 high-true, x:1 low-true
        c_d.out = channel_edge_level_select[i][0] ? ~pwm_lvl : pwm_lvl; // RULE20
        if (tk.tick && tk.at_mod) begin
          set_ev = 1'b1;
        end
      end else if (ch_mode[i] == ptmr_pkg::PTMR_MODE_CAP) begin
        if (ch_value_we[i]) begin
          c_d.val = ch_value_wr[i];
        end
        if ((channel_edge_level_select[i][0] && rise) ||
            (channel_edge_level_select[i][1] && fall)) begin // RULE18
          c_d.val  = tk.cnt;
          set_ev   = 1'b1;
        end
      end else begin
        if (ch_value_we[i]) begin
          c_d.val = ch_value_wr[i];
        end
        if (tk.tick && hit) begin // RULE12
          set_ev = 1'b1;
          case (channel_edge_level_select[i]) // RULE19
            2'h1:    c_d.out = ~c_q.out;
            2'h2:    c_d.out = 1'b0;
            2'h3:    c_d.out = 1'b1;
            default: c_d.out = c_q.out;
          endcase
        end
      end
      // New event wins over a clear in the same cycle
      if (ch_flag_clear[i]) begin
        c_d.flag = 1'b0;
      end
      if (set_ev) begin
        c_d.flag = 1'b1;
      end
      // Timer owns pin when outputting; pin is input when capturing or routed; port when unused
      if (active && (center_aligned_pwm || ch_mode[i] != ptmr_pkg::PTMR_MODE_CAP) &&
          !(i == 0 && comparator_capture_route)) begin // RULE14
        c_d.oe = 1'b1;
        c_d.po = c_d.out;
      end else if (active || (i == 0 && comparator_capture_route)) begin
        c_d.oe = 1'b0; // RULE1
        c_d.po = 1'b0;
      end else begin
        c_d.oe = port_dir[i]; // RULE15
        c_d.po = port_data[i];
      end
      c_d.pu = pullup_req[i] & ~c_d.oe;
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        c_q <= '0; // RULE9
      end else begin
        c_q <= c_d;
      end
    end

    assign timer_channel_pin_out[i] = c_q.po;
    assign timer_channel_pin_oe[i]  = c_q.oe;
    assign pin_pullup_en[i]         = c_q.pu;
    assign ch_value_q[i]            = c_q.val;
    assign ch_flag[i]               = c_q.flag;
    assign ch_irq[i]                = c_q.flag; // RULE21
  end
endmodule // ptmr_top

// [ptmr_pkg.sv]
// Constants and types for the pulse timer module
// Behaviour
// RULE1: Comparator route feeds channel 0 capture, frees pin
// RULE2: Clock source 1:1 selects external pin clock
// RULE3: Counter clock from bus, fixed or pin
// RULE4: Prescaler divides by powers of two to 128
// RULE5: 16-bit counter, up or up/down in center mode
// RULE6: Modulo bounds count; zero or all-ones free-runs
// RULE7: Reading count never disturbs counting
// RULE8: Any counter byte write clears counter
// RULE9: After reset timer disabled, pins inputs, pullups off
// RULE10: External clock synchronised to bus clock
// RULE11: External clock at most quarter bus rate
// RULE12: Clock-shared channel keeps software compare function
// RULE13: Software sets edge select 0:0 on clock pin
// RULE14: Timer-owned pin ignores port data and direction
// RULE15: Pin returns to port when unused
// RULE16: Channels configured independently
// RULE17: Center-aligned mode switches all channels together
// RULE18: Capture on rising, falling or either edge
// RULE19: Compare match sets, clears or toggles output
// RULE20: PWM polarity selectable per channel
// RULE21: One request per channel plus terminal count
// RULE22: Clock field 00 off, 01 bus, 10 fixed, 11 pin
// RULE23: Prescale field divides by two to field power
// RULE24: Overflow flag on wrap, or step down in center
// RULE25: Two channels, each with value and pin
package ptmr_pkg;
  localparam int          PTMR_NCH       = 2;
  localparam logic [1:0]  PTMR_CLK_OFF   = 2'h0;
  localparam logic [1:0]  PTMR_CLK_BUS   = 2'h1;
  localparam logic [1:0]  PTMR_CLK_FIXED = 2'h2;
  localparam logic [1:0]  PTMR_CLK_EXT   = 2'h3;
  localparam logic [1:0]  PTMR_MODE_CAP  = 2'h0;
  localparam logic [1:0]  PTMR_MODE_CMP  = 2'h1;
  localparam logic [15:0] PTMR_MOD_ZERO  = 16'h0000;
  localparam logic [15:0] PTMR_MOD_FULL  = 16'hffff;
  localparam logic [15:0] PTMR_CNT_RST   = 16'h0000;
  localparam logic [6:0]  PTMR_PS_RST    = 7'h00;
  localparam int          PTMR_BUS_MHZ   = 50;

  typedef enum logic [0:0] {
    PTMR_UP   = 1'b0,
    PTMR_DOWN = 1'b1
  } ptmr_dir_e;

  typedef struct packed {
    logic [2:0] ext_sync;
    logic [2:0] fix_sync;
    logic [6:0] ps_cnt;
    logic [15:0] cnt;
    ptmr_dir_e  dir;
    logic       ovf;
  } ptmr_core_s;
endpackage

// [ptmr_tick_if.sv]
// Count tick and counter state shared with channel logic
`timescale 1ns/1ps
interface ptmr_tick_if;
  logic        tick;
  logic [15:0] cnt;
  logic        dir_down;
  logic        at_mod;
  modport core (output tick, output cnt, output dir_down, output at_mod);
  modport chan (input tick, input cnt, input dir_down, input at_mod);
endinterface

// [ptmr_core.sv]
// Clock select, prescaler, 16-bit counter and overflow flag
`timescale 1ns/1ps
module ptmr_core (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  clock_source_field,
  input  wire logic [2:0]  prescale_select,
  input  wire logic        center_aligned_pwm,
  input  wire logic [15:0] counter_modulo_value,
  input  wire logic        cnt_write,
  input  wire logic        ovf_clear,
  input  wire logic        fixed_system_clock,
  input  wire logic        external_clock_input,
  output      logic        ovf_q,
  ptmr_tick_if.core        tk
);
  ptmr_pkg::ptmr_core_s s_q;
  ptmr_pkg::ptmr_core_s s_d;
  logic                 src_tick;
  logic                 pre_tick;
  logic                 free_run;
  logic [6:0]           ps_mask;
  logic                 wrap;

  always_comb begin
    s_d = s_q;
    // Stage 0 feeds stage 1 only; edge logic looks at stages 1 and 2
    s_d.ext_sync = {s_q.ext_sync[1:0], external_clock_input}; // RULE10
    s_d.fix_sync = {s_q.fix_sync[1:0], fixed_system_clock};
    case (clock_source_field) // RULE3 RULE22
      ptmr_pkg::PTMR_CLK_BUS:   src_tick = 1'b1;
      ptmr_pkg::PTMR_CLK_FIXED: src_tick = s_q.fix_sync[1] & ~s_q.fix_sync[2];
      ptmr_pkg::PTMR_CLK_EXT:   src_tick = s_q.ext_sync[1] & ~s_q.ext_sync[2]; // RULE2
      default:                  src_tick = 1'b0;
    endcase
    ps_mask  = 7'((8'h01 << prescale_select) - 8'h01); // RULE4 RULE23
    pre_tick = src_tick && ((s_q.ps_cnt & ps_mask) == ps_mask);
    if (src_tick) begin
      s_d.ps_cnt = s_q.ps_cnt + 7'h01;
    end
    free_run = (counter_modulo_value == ptmr_pkg::PTMR_MOD_ZERO) ||
               (counter_modulo_value == ptmr_pkg::PTMR_MOD_FULL); // RULE6
    wrap = 1'b0;
    if (pre_tick) begin
      if (center_aligned_pwm) begin // RULE5
        if (s_q.dir == ptmr_pkg::PTMR_UP) begin
          if (!free_run && s_q.cnt >= counter_modulo_value) begin
            s_d.dir = ptmr_pkg::PTMR_DOWN;
            s_d.cnt = s_q.cnt - 16'h0001;
            wrap    = 1'b1; // RULE24
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end else if (s_q.cnt <= 16'h0001) begin
          s_d.dir = ptmr_pkg::PTMR_UP;
          s_d.cnt = s_q.cnt - 16'h0001;
          if (s_q.cnt == 16'h0000) begin
            s_d.cnt = 16'h0001;
          end
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end else begin
        s_d.dir = ptmr_pkg::PTMR_UP;
        if (!free_run && s_q.cnt >= counter_modulo_value) begin
          s_d.cnt = ptmr_pkg::PTMR_CNT_RST;
          wrap    = 1'b1; // RULE24
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
          wrap    = (s_q.cnt == 16'hffff);
        end
      end
    end
    if (cnt_write) begin // RULE8
      s_d.cnt    = ptmr_pkg::PTMR_CNT_RST;
      s_d.dir    = ptmr_pkg::PTMR_UP;
      s_d.ps_cnt = ptmr_pkg::PTMR_PS_RST;
    end
    // New overflow wins over a clear in the same cycle
    if (ovf_clear) begin
      s_d.ovf = 1'b0;
    end
    if (wrap) begin
      s_d.ovf = 1'b1; // RULE24
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0; // RULE9
    end else begin
      s_q <= s_d;
    end
  end

  assign ovf_q       = s_q.ovf;
  assign tk.tick     = pre_tick;
  assign tk.cnt      = s_q.cnt; // RULE7
  assign tk.dir_down = (s_q.dir == ptmr_pkg::PTMR_DOWN);
  assign tk.at_mod   = (s_q.cnt == counter_modulo_value);
endmodule // ptmr_core

// [ptmr_checker.sv]
// Port-level assertions for the pulse timer module
`timescale 1ns/1ps
module ptmr_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [1:0]  clock_source_field,
  input wire logic [2:0]  prescale_select,
  input wire logic        center_aligned_pwm,
  input wire logic [15:0] counter_modulo_value,
  input wire logic        cnt_write,
  input wire logic        ovf_clear,
  input wire logic        comparator_capture_route,
  input wire logic [1:0]  channel_edge_level_select [2],
  input wire logic [1:0]  port_dir,
  input wire logic [1:0]  timer_channel_pin_oe,
  input wire logic [15:0] timer_count_value,
  input wire logic [1:0]  ch_flag,
  input wire logic [1:0]  ch_irq,
  input wire logic        overflow_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_off_frozen: assert property (
    (clock_source_field == 2'h0 && !cnt_write)[*3] |=> $stable(timer_count_value))
    else $error("count moved while off");
  a_free_step: assert property (
    (clock_source_field == 2'h1 && prescale_select == 3'h0 && !center_aligned_pwm
     && !cnt_write && counter_modulo_value == 16'h0000)[*4]
    |=> timer_count_value == $past(timer_count_value) + 16'h0001)
    else $error("free count skipped");
  a_write_clear: assert property (cnt_write |-> ##2 timer_count_value == 16'h0000)
    else $error("count not cleared");
  // Flag output trails the clear by two cycles
  a_ovf_sticky: assert property (
    overflow_flag && !ovf_clear && !$past(ovf_clear) |=> overflow_flag)
    else $error("overflow dropped");
  a_ovf_wrap: assert property (
    $rose(overflow_flag) && !center_aligned_pwm |-> timer_count_value == 16'h0000)
    else $error("overflow away from wrap");
  a_irq_match: assert property (ch_irq == ch_flag)
    else $error("request differs from flag");
  a_route_pin: assert property (
    comparator_capture_route [*2] |-> !timer_channel_pin_oe[0])
    else $error("routed pin driven");
  a_free_pin: assert property (
    (channel_edge_level_select[1] == 2'h0)[*2] |-> timer_channel_pin_oe[1] == $past(port_dir[1]))
    else $error("released pin driven");
  c_wrap: cover property ($rose(overflow_flag));
  c_capture: cover property ($rose(ch_flag[0]));
  c_center: cover property (center_aligned_pwm && $rose(overflow_flag));
endmodule // ptmr_checker

bind ptmr_top ptmr_checker u_checker (.*);

// [ptmr_far_model.sv]
// Far-side model: timer clock sources and channel pin wires
`timescale 1ns/1ps
module ptmr_far_model #(
  parameter int EXT_HALF = 4,
  parameter int FIX_HALF = 2
) (
  input  wire logic       clk,
  input  wire logic       ext_run,
  input  wire logic [1:0] pin_drive,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  output      logic       ext_clk = 1'b0,
  output      logic       fix_clk = 1'b0,
  output      logic [1:0] pin_in
);
  int ext_n = 0;
  int fix_n = 0;
  // Timer drive wins over the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drive);
  always @(posedge clk) begin
    fix_n <= (fix_n + 1) % FIX_HALF;
    if (fix_n == 0) begin
      fix_clk <= ~fix_clk;
    end
    // Eighth of bus rate, parked low outside bursts
    ext_n <= ext_run ? (ext_n + 1) % EXT_HALF : 0;
    if (!ext_run) begin
      ext_clk <= 1'b0;
    end else if (ext_n == EXT_HALF - 1) begin
      ext_clk <= ~ext_clk;
    end
  end
endmodule // ptmr_far_model

// [testbench.sv]
// Self-checking testbench for the pulse timer module
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [1:0]  clock_source_field = 2'h0;
  logic [2:0]  prescale_select = 3'h0;
  logic        center_aligned_pwm = 1'b0;
  logic [15:0] counter_modulo_value = 16'h0000;
  logic        cnt_write = 1'b0;
  logic        ovf_clear = 1'b0;
  logic        comparator_capture_route = 1'b0;
  logic        analog_comparator = 1'b0;
  logic        ext_run = 1'b0;
  logic [1:0]  ch_mode [2] = '{2'h0, 2'h0};
  logic [1:0]  channel_edge_level_select [2] = '{2'h0, 2'h0};
  logic [15:0] ch_value_wr [2] = '{16'h0000, 16'h0000};
  logic [1:0]  ch_value_we = 2'h0;
  logic [1:0]  ch_flag_clear = 2'h0;
  logic [1:0]  pin_drive = 2'h0;
  logic [1:0]  port_data = 2'h0;
  logic [1:0]  port_dir = 2'h0;
  logic [1:0]  pullup_req = 2'h0;
  logic        fixed_system_clock;
  logic        external_clock_input;
  logic [1:0]  timer_channel_pin_in;
  logic [1:0]  timer_channel_pin_out;
  logic [1:0]  timer_channel_pin_oe;
  logic [1:0]  pin_pullup_en;
  logic [15:0] timer_count_value;
  logic [15:0] ch_value_q [2];
  logic [1:0]  ch_flag;
  logic        overflow_flag;
  logic        ovf_irq;
  logic [15:0] v;
  int          n;
  int          err_count = 0;
  int          total_checks = 0;

  ptmr_top u_dut (.*, .ch_irq());
  ptmr_far_model u_far (.clk(clk), .ext_run(ext_run), .pin_drive(pin_drive),
    .pin_out(timer_channel_pin_out), .pin_oe(timer_channel_pin_oe),
    .ext_clk(external_clock_input), .fix_clk(fixed_system_clock),
    .pin_in(timer_channel_pin_in));

  always #10 clk = ~clk;

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    chk(nm, 16'h1, {15'h0, (g >= lo && g <= hi)});
  endtask
  task automatic cfg(input logic [1:0] f, input logic [2:0] p, input logic [15:0] m,
                     input logic c);
    clock_source_field = f;
    prescale_select = p;
    counter_modulo_value = m;
    center_aligned_pwm = c;
    cnt_write = 1'b1;
    cyc(1);
    cnt_write = 1'b0;
    cyc(4);
  endtask
  // Also clears the channel flag
  task automatic chan(input int i, input logic [1:0] md, input logic [1:0] el,
                      input logic [15:0] val);
    ch_mode[i] = md;
    channel_edge_level_select[i] = el;
    ch_value_wr[i] = val;
    ch_value_we[i] = 1'b1;
    ch_flag_clear[i] = 1'b1;
    cyc(1);
    ch_value_we[i] = 1'b0;
    ch_flag_clear[i] = 1'b0;
    cyc(2);
  endtask
  task automatic span(output int k);
    v = timer_count_value;
    k = 0;
    while (timer_count_value === v && k < 400) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic highs(output int k);
    k = 0;
    repeat (40) begin
      cyc(1);
      k += (timer_channel_pin_out[1] === 1'b1);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    err_count++;
    tally_and_finish();
  end

  initial begin
    cyc(4);
    reset = 1'b0;
    cyc(1);
    chk("rst", 16'h0, {timer_count_value[11:0], timer_channel_pin_oe, pin_pullup_en});
    cfg(2'h1, 3'h0, 16'h0003, 1'b0);
    for (int k = 0; k < 12; k++) begin
      v = timer_count_value;
      cyc(1);
      chk("walk", (v == 16'h3) ? 16'h0 : v + 16'h1, timer_count_value);
    end
    chk("ovf_set", 16'h1, {15'h0, overflow_flag});
    clock_source_field = 2'h0;
    cyc(3);
    v = timer_count_value;
    ovf_clear = 1'b1;
    cyc(1);
    ovf_clear = 1'b0;
    cyc(20);
    chk("off_hold", v, timer_count_value);
    chk("ovf_clr", 16'h0, {15'h0, overflow_flag});
    for (int p = 0; p < 8; p++) begin
      cfg(2'h1, p[2:0], 16'h0000, 1'b0);
      span(n);
      span(n);
      chk("prescale", 16'h1 << p, n[15:0]);
    end
    $display("test counter done");
    cfg(2'h1, 3'h0, 16'h0003, 1'b1);
    n = 0;
    repeat (16) begin
      v = timer_count_value;
      cyc(1);
      n += (timer_count_value < v);
      rng("center_aligned_pwm_max", 0, 3, timer_count_value);
    end
    rng("center_aligned_pwm_down", 8, 9, n[15:0]);
    chk("center_aligned_pwm_ovf", 16'h3, {14'h0, overflow_flag, ovf_irq});
    cfg(2'h3, 3'h0, 16'h0000, 1'b0);
    ext_run = 1'b1;
    cyc(80);
    ext_run = 1'b0;
    rng("ext_rate", 8, 10, timer_count_value);
    cfg(2'h2, 3'h0, 16'h0000, 1'b0);
    cyc(80);
    rng("fix_rate", 18, 22, timer_count_value);
    $display("test clocks done");
    pullup_req = 2'h1;
    for (int e = 1; e < 4; e++) begin
      chan(0, 2'h0, e[1:0], 16'h0000);
      pin_drive[0] = 1'b1;
      cyc(4);
      chk("cap_rise", {15'h0, e[0]}, {15'h0, ch_flag[0]});
      chan(0, 2'h0, e[1:0], 16'h0000);
      pin_drive[0] = 1'b0;
      cyc(4);
      chk("cap_fall", {15'h0, e[1]}, {15'h0, ch_flag[0]});
    end
    comparator_capture_route = 1'b1;
    chan(0, 2'h0, 2'h1, 16'h0000);
    pin_drive[0] = 1'b1;
    cyc(4);
    analog_comparator = 1'b1;
    cyc(4);
    chk("route", 16'h2, {14'h0, ch_flag[0], timer_channel_pin_oe[0]});
    chk("pullup", 16'h1, {14'h0, pin_pullup_en});
    $display("test capture done");
    cfg(2'h1, 3'h0, 16'h0003, 1'b0);
    chan(1, 2'h1, 2'h3, 16'h0002);
    cyc(6);
    chk("cmp_set", 16'h3, {14'h0, timer_channel_pin_oe[1], timer_channel_pin_out[1]});
    chan(1, 2'h1, 2'h2, 16'h0002);
    cyc(6);
    chk("cmp_clr", 16'h2, {14'h0, timer_channel_pin_oe[1], timer_channel_pin_out[1]});
    chan(1, 2'h1, 2'h1, 16'h0002);
    v[0] = timer_channel_pin_out[1];
    cyc(4);
    chk("cmp_tgl", {15'h0, ~v[0]}, {15'h0, timer_channel_pin_out[1]});
    chan(1, 2'h1, 2'h0, 16'h0002);
    cyc(6);
    chk("cmp_soft", 16'h1, {14'h0, timer_channel_pin_oe[1], ch_flag[1]});
    chk("ch_val", 16'h0002, ch_value_q[1]);
    chan(1, 2'h2, 2'h2, 16'h0001);
    cyc(8);
    highs(n);
    rng("pwm_high", 8, 12, n[15:0]);
    chan(1, 2'h2, 2'h1, 16'h0001);
    port_data = 2'h3;
    cyc(8);
    highs(n);
    rng("pwm_low", 28, 32, n[15:0]);
    $display("test channels done");
    tally_and_finish();
  end
endmodule // testbench
